// File: verilog/line_loss_of_signal_monitor.sv
// one receive channel: loss-of-signal detection, status, muting and rail output
// assumes a classic wishbone master on ref_clk and an analog front end with digital
// comparator outputs; the recovered line clock is sampled as an ordinary input
//
// Contract
// - E3: declare loss when the amplitude indication reaches -35 dB or lower.
// - E3: clear loss only when the amplitude indication returns to -15 dB or higher.
// - Raise the loss indicator 10 to 255 unit intervals after loss begins.
// - Drop the loss indicator 10 to 255 unit intervals after signal returns.
// - DS3: combined loss equals analog loss OR digital loss.
// - DS3/STS-1: assert analog loss when amplitude is below the declare threshold.
// - Deassert analog loss only above the higher clear threshold, giving hysteresis.
// - Status bit 2 reads one while analog loss is declared.
// - Detect-control bit 2 set stops the analog detector declaring.
// - Declare digital loss after a zero run of nominally 160 bits.
// - Clear digital loss after four consecutive 32-bit windows of ten or more ones.
// - Status bit 1 reads one while digital loss is declared.
// - Detect-control bit 1 set stops the digital detector declaring.
// - Both detector disables set means the channel never declares loss.
// - With muting on, hold both data rails at zero while loss is declared.
// - After loss clears, a muted channel passes recovered data again.
// - Output-control bit 3 set enables muting on loss for this channel.
// - Deliver recovered data in single-rail or dual-rail format as configured.
// - Loss output pin and loss status bit follow every declare and clear.
// - Raise the lock-loss output while the clock recovery loop is training.
module line_loss_of_signal_monitor (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // recovered line side
  input wire logic line_clk,
  input wire logic line_pos,
  input wire logic line_neg,
  // analog front end and clock recovery
  input wire logic amp_below_declare,
  input wire logic amp_above_clear,
  input wire logic pll_training,
  input wire logic drive_monitor_flag,
  // strap-style pins
  input wire logic e3_mode,
  input wire logic global_mute_on_loss,
  // alarms
  output logic receive_signal_loss,
  output logic receive_lock_loss,
  // terminal side
  output logic recovered_positive_rail,
  output logic recovered_negative_rail,
  output logic recovered_clock_out,
  // front end control
  output logic equalizer_enable,
  output logic line_codec_disable,
  output logic receiver_shutdown
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam int NUM_SYNC = 8;

  logic [NUM_SYNC-1:0] async_in;
  logic [NUM_SYNC-1:0] meta_ff;
  logic [NUM_SYNC-1:0] sync_ff;

  assign async_in = {global_mute_on_loss, e3_mode, drive_monitor_flag, pll_training,
                     amp_above_clear, amp_below_declare, line_neg, line_pos} ;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else if (clk_en) begin
          meta_ff[gi] <= async_in[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  wire pos_s = sync_ff[0];
  wire neg_s = sync_ff[1];
  wire below_s = sync_ff[2];
  wire above_s = sync_ff[3];
  wire training_s = sync_ff[4];
  wire drive_mon_s = sync_ff[5];
  wire e3_s = sync_ff[6];
  wire global_mute_s = sync_ff[7];

  // ************************************************************
  // line clock edge finder
  // ************************************************************
  logic lclk_meta_ff;
  logic lclk_sync_ff;
  logic lclk_prev_ff;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lclk_meta_ff <= 1'b0;
      lclk_sync_ff <= 1'b0;
      lclk_prev_ff <= 1'b0;
    end else if (clk_en) begin
      lclk_meta_ff <= line_clk;
      lclk_sync_ff <= lclk_meta_ff;
      lclk_prev_ff <= lclk_sync_ff;
    end
  end

  // one strobe per unit interval
  ui_if ui ();
  assign ui.tick = clk_en && lclk_sync_ff && !lclk_prev_ff;
  assign ui.bit_one = pos_s || neg_s;

  // ************************************************************
  // register file
  // ************************************************************
  logic [4:0] detect_ctrl_ff;
  logic [4:0] output_ctrl_ff;
  logic [4:0] nxt_detect_ctrl;
  logic [4:0] nxt_output_ctrl;
  logic [31:0] nxt_rd_data;
  logic ack_ff;
  logic [31:0] rd_data_ff;
  logic [4:0] alarm_status;

  wire bus_req = wb_cyc_i && wb_stb_i;
  wire wr_commit = bus_req && wb_we_i && ack_ff && wb_sel_i[0];
  wire hit_detect = wb_adr_i == los_pkg::ADDR_DETECT_CTRL;
  wire hit_output = wb_adr_i == los_pkg::ADDR_OUTPUT_CTRL;
  wire hit_status = wb_adr_i == los_pkg::ADDR_ALARM_STATUS;

  function automatic logic [4:0] merge_bits(input logic [4:0] old_v, input logic [4:0] new_v,
                                            input logic [4:0] mask);
    merge_bits = (old_v & ~mask) | (new_v & mask);
  endfunction

  assign nxt_detect_ctrl = merge_bits(detect_ctrl_ff, wb_dat_i[4:0], los_pkg::CTRL_WRITE_MASK);
  assign nxt_output_ctrl = merge_bits(output_ctrl_ff, wb_dat_i[4:0], los_pkg::OUT_WRITE_MASK);

  assign nxt_rd_data = hit_status ? {27'h0000000, alarm_status} :
                       hit_detect ? {27'h0000000, detect_ctrl_ff} :
                       hit_output ? {27'h0000000, output_ctrl_ff} : 32'h00000000;

  // ack one cycle after the request; write lands at the edge that ends the ack cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
      rd_data_ff <= 32'h00000000;
    end else if (clk_en) begin
      ack_ff <= bus_req && !ack_ff;
      if (bus_req && !ack_ff) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      detect_ctrl_ff <= los_pkg::DETECT_CTRL_RST;
      output_ctrl_ff <= los_pkg::OUTPUT_CTRL_RST;
    end else if (clk_en && wr_commit) begin
      if (hit_detect) begin
        detect_ctrl_ff <= nxt_detect_ctrl;
      end
      if (hit_output) begin
        output_ctrl_ff <= nxt_output_ctrl;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_data_ff;

  wire amp_dis = detect_ctrl_ff[los_pkg::DET_AMPLITUDE_DIS];
  wire zero_dis = detect_ctrl_ff[los_pkg::DET_ZERO_RUN_DIS];
  wire chan_mute = output_ctrl_ff[los_pkg::OUT_MUTE];
  wire clk_inv = output_ctrl_ff[los_pkg::OUT_CLOCK_INV];
  wire shut_off = output_ctrl_ff[los_pkg::OUT_SHUTDOWN];
  wire single_rail = output_ctrl_ff[los_pkg::OUT_SINGLE_RAIL];

  // ************************************************************
  // analog amplitude loss with hysteresis
  // ************************************************************
  logic analog_loss_ff;

  // front end applies the e3 or ds3/sts-1 thresholds to its comparators
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      analog_loss_ff <= 1'b0;
    end else if (clk_en) begin
      if (amp_dis) begin
        analog_loss_ff <= 1'b0;
      end else if (below_s) begin
        analog_loss_ff <= 1'b1;
      end else if (above_s) begin
        analog_loss_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // digital loss and combined, timed indication
  // ************************************************************
  logic digital_loss;
  logic loss_declared;

  zero_run_detector u_zero_run (
    .ref_clk(ref_clk),
    .reset(reset),
    .ui(ui),
    .detector_disable(zero_dis),
    .loss_ff(digital_loss)
  );

  // e3 uses amplitude only; both disables gate the raw state at once
  wire both_dis = amp_dis && zero_dis;
  wire raw_loss = !both_dis && (e3_s ? analog_loss_ff : (analog_loss_ff || digital_loss));

  loss_timer u_loss_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .ui(ui),
    .raw_loss(raw_loss),
    .declared_ff(loss_declared)
  );

  // ************************************************************
  // alarm outputs and status
  // ************************************************************
  logic lock_loss_ff;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lock_loss_ff <= 1'b0;
    end else if (clk_en) begin
      lock_loss_ff <= training_s;
    end
  end

  assign receive_signal_loss = loss_declared;
  assign receive_lock_loss = lock_loss_ff;
  assign alarm_status = {lock_loss_ff, loss_declared, analog_loss_ff, digital_loss, drive_mon_s};

  // ************************************************************
  // recovered data to the terminal
  // ************************************************************
  logic pos_out_ff;
  logic neg_out_ff;
  logic clk_out_ff;

  wire mute_en = chan_mute || global_mute_s;
  wire silence = shut_off || (mute_en && loss_declared);
  wire nxt_pos = silence ? 1'b0 : (single_rail ? ui.bit_one : pos_s);
  wire nxt_neg = silence || single_rail ? 1'b0 : neg_s;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pos_out_ff <= 1'b0;
      neg_out_ff <= 1'b0;
      clk_out_ff <= 1'b0;
    end else if (clk_en) begin
      clk_out_ff <= shut_off ? 1'b0 : lclk_sync_ff ^ clk_inv;
      if (ui.tick || silence) begin
        pos_out_ff <= nxt_pos;
        neg_out_ff <= nxt_neg;
      end else if (single_rail) begin
        neg_out_ff <= 1'b0;
      end
    end
  end

  assign recovered_positive_rail = pos_out_ff;
  assign recovered_negative_rail = neg_out_ff;
  assign recovered_clock_out = clk_out_ff;
  assign equalizer_enable = detect_ctrl_ff[los_pkg::DET_EQUALIZER_EN];
  assign line_codec_disable = detect_ctrl_ff[los_pkg::DET_CODEC_DIS];
  assign receiver_shutdown = shut_off;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_muted_loss;
    clk_en && mute_en && loss_declared;
  endsequence

  sequence s_rails_zero;
    !recovered_positive_rail && !recovered_negative_rail;
  endsequence

  a_mute_rails_zero: assert property (
    s_muted_loss |=> s_rails_zero)
    else $error("rails not muted during declared loss");
  a_resume_after_clear: assert property (
    clk_en && !silence && ui.tick && pos_s && !single_rail |=> recovered_positive_rail)
    else $error("positive rail not passed after loss cleared");
  a_single_rail_neg: assert property (
    clk_en && single_rail |=> !recovered_negative_rail)
    else $error("negative rail active in single-rail mode");
  a_analog_declare: assert property (
    clk_en && below_s && !amp_dis |=> analog_loss_ff)
    else $error("analog loss not declared below threshold");
  a_analog_hold: assert property (
    clk_en && analog_loss_ff && !above_s && !amp_dis |=> analog_loss_ff)
    else $error("analog loss cleared without clear threshold");
  a_analog_disable: assert property (
    clk_en && amp_dis |=> !analog_loss_ff)
    else $error("disabled amplitude detector still declares");
  a_both_disabled: assert property (
    amp_dis && zero_dis && !loss_declared |=> !loss_declared)
    else $error("loss declared with both detectors disabled");
  a_status_read: assert property (
    clk_en && bus_req && !ack_ff && !wb_we_i && hit_status |=>
      wb_dat_o[4:0] == $past(alarm_status) && wb_ack_o)
    else $error("status read does not return detector state");
  a_ack_single: assert property (
    wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_analog_clear: assert property (
    clk_en && analog_loss_ff && above_s && !below_s |=> !analog_loss_ff)
    else $error("analog loss kept above clear threshold");
  a_resume_neg: assert property (
    clk_en && !silence && ui.tick && neg_s && !single_rail |=> recovered_negative_rail)
    else $error("negative rail not passed after loss cleared");
  a_lock_follows: assert property (
    clk_en && training_s |=> receive_lock_loss)
    else $error("lock loss not raised while training");
  a_lock_clear: assert property (
    clk_en && !training_s |=> !receive_lock_loss)
    else $error("lock loss raised without training");

endmodule : line_loss_of_signal_monitor

// File: verilog/los_pkg.sv
// constants of the per-channel loss-of-signal monitor
// assumes a 32-bit classic wishbone slave port and one recovered line channel
package los_pkg;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_ALARM_STATUS = 8'h00;
  localparam logic [7:0] ADDR_DETECT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_OUTPUT_CTRL = 8'h08;

  // channel_alarm_status fields
  localparam int ST_DRIVE_MON = 0;
  localparam int ST_DIGITAL_LOSS = 1;
  localparam int ST_ANALOG_LOSS = 2;
  localparam int ST_SIGNAL_LOSS = 3;
  localparam int ST_LOCK_LOSS = 4;

  // receive_detect_control fields
  localparam int DET_EQUALIZER_EN = 0;
  localparam int DET_ZERO_RUN_DIS = 1;
  localparam int DET_AMPLITUDE_DIS = 2;
  localparam int DET_CODEC_DIS = 3;

  // receive_output_control fields
  localparam int OUT_CLOCK_INV = 1;
  localparam int OUT_SHUTDOWN = 2;
  localparam int OUT_MUTE = 3;
  localparam int OUT_SINGLE_RAIL = 4;

  localparam logic [4:0] DETECT_CTRL_RST = 5'h00;
  localparam logic [4:0] OUTPUT_CTRL_RST = 5'h00;
  localparam logic [4:0] CTRL_WRITE_MASK = 5'h0F;
  localparam logic [4:0] OUT_WRITE_MASK = 5'h1E;

  // ************************************************************
  // detector timing, in unit intervals
  // ************************************************************
  localparam logic [7:0] ZERO_RUN_LIMIT = 8'hA0;
  localparam logic [4:0] WINDOW_LAST_BIT = 5'h1F;
  localparam logic [5:0] WINDOW_ONES_MIN = 6'h0A;
  localparam logic [2:0] GOOD_WINDOWS = 3'h4;
  localparam logic [7:0] LOSS_QUAL_UI = 8'h10;
  localparam int SYNC_STAGES = 2;

endpackage : los_pkg

// File: verilog/ui_if.sv
// unit-interval strobe and sampled bit shared by the channel's detectors
// assumes every signal is driven on ref_clk by the channel top
interface ui_if;
  logic tick;
  logic bit_one;

  modport src (
    output tick,
    output bit_one
  );

  modport sink (
    input tick,
    input bit_one
  );
endinterface : ui_if

// File: verilog/zero_run_detector.sv
// digital loss detector: long zero runs declare, dense windows clear
// assumes ui.tick is a one-cycle strobe per received bit, already clock-enabled
module zero_run_detector (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bit stream
  ui_if.sink ui,
  // control and state
  input wire logic detector_disable,
  output logic loss_ff
);

  logic [7:0] zero_cnt_ff;
  logic [4:0] bit_cnt_ff;
  logic [5:0] ones_cnt_ff;
  logic [2:0] good_cnt_ff;

  wire [7:0] nxt_zero_cnt = ui.bit_one ? 8'h00 : (zero_cnt_ff == 8'hFF ? zero_cnt_ff : zero_cnt_ff + 8'h01);
  wire [5:0] ones_total = ones_cnt_ff + {5'h00, ui.bit_one};
  wire window_end = bit_cnt_ff == los_pkg::WINDOW_LAST_BIT;
  wire window_good = ones_total >= los_pkg::WINDOW_ONES_MIN;
  wire [2:0] nxt_good_cnt = window_good ? good_cnt_ff + 3'h1 : 3'h0;
  wire declare_now = nxt_zero_cnt >= los_pkg::ZERO_RUN_LIMIT;
  wire clear_now = window_end && nxt_good_cnt == los_pkg::GOOD_WINDOWS;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      zero_cnt_ff <= 8'h00;
      bit_cnt_ff <= 5'h00;
      ones_cnt_ff <= 6'h00;
      good_cnt_ff <= 3'h0;
    end else if (ui.tick) begin
      zero_cnt_ff <= nxt_zero_cnt;
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      ones_cnt_ff <= window_end ? 6'h00 : ones_total;
      if (window_end) begin
        good_cnt_ff <= clear_now ? 3'h0 : nxt_good_cnt;
      end
    end
  end

  // declare wins over clear in the same bit
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      loss_ff <= 1'b0;
    end else if (detector_disable) begin
      loss_ff <= 1'b0;
    end else if (ui.tick && declare_now) begin
      loss_ff <= 1'b1;
    end else if (ui.tick && clear_now) begin
      loss_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_zero_run_declare: assert property (
    ui.tick && !ui.bit_one && zero_cnt_ff == 8'h9F && !detector_disable |=> loss_ff)
    else $error("zero run of 160 did not declare digital loss");
  a_dense_clear: assert property (
    loss_ff && !detector_disable ##1 !loss_ff |-> $past(good_cnt_ff) == 3'h3 && $past(window_end))
    else $error("digital loss cleared without four good windows");
  a_zero_disable: assert property (
    detector_disable |=> !loss_ff)
    else $error("disabled zero-run detector still declares");

endmodule : zero_run_detector

// File: verilog/loss_timer.sv
// qualifies the raw loss state over a fixed run of unit intervals
// assumes ui.tick is a one-cycle strobe per received bit, already clock-enabled
module loss_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bit timing
  ui_if.sink ui,
  // loss state
  input wire logic raw_loss,
  output logic declared_ff
);

  logic [7:0] run_cnt_ff;

  wire differs = raw_loss != declared_ff;
  wire run_done = run_cnt_ff == los_pkg::LOSS_QUAL_UI - 8'h01;

  // both edges of the indication need the same unbroken run
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      run_cnt_ff <= 8'h00;
      declared_ff <= 1'b0;
    end else if (ui.tick) begin
      if (!differs) begin
        run_cnt_ff <= 8'h00;
      end else if (run_done) begin
        run_cnt_ff <= 8'h00;
        declared_ff <= raw_loss;
      end else begin
        run_cnt_ff <= run_cnt_ff + 8'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_declare_after_run: assert property (
    $rose(declared_ff) |-> $past(run_cnt_ff) == los_pkg::LOSS_QUAL_UI - 8'h01 && $past(raw_loss))
    else $error("loss declared before its qualifying run");
  a_clear_after_run: assert property (
    $fell(declared_ff) |-> $past(run_cnt_ff) == los_pkg::LOSS_QUAL_UI - 8'h01 && !$past(raw_loss))
    else $error("loss cleared before its qualifying run");
  a_run_bounded: assert property (
    run_cnt_ff < los_pkg::LOSS_QUAL_UI)
    else $error("qualifying run counter overran");

endmodule : loss_timer

// File: verification/line_source.sv
// line source model: recovered line clock and rails, as a receiver front end delivers them
// assumes the bench selects all-ones (alternating marks) or all-zeros traffic
module line_source (
  // control
  input wire logic send_ones,
  // line
  output logic line_clk,
  output logic line_pos,
  output logic line_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase_ff;
  // ************************************************************
  // free-running recovered clock, 400 ns, unrelated phase
  // ************************************************************
  initial begin
    line_clk = 1'b0;
    line_pos = 1'b0;
    line_neg = 1'b0;
    phase_ff = 1'b0;
    #137;
    forever begin
      #200 line_clk = ~line_clk;
    end
  end
  // data moves on the falling edge, away from the sampling edge
  always @(negedge line_clk) begin
    phase_ff <= ~phase_ff;
    line_pos <= send_ones & phase_ff;
    line_neg <= send_ones & ~phase_ff;
  end
endmodule // line_source

// File: verification/tb_line_loss_of_signal_monitor.sv
// self-checking bench of one loss-of-signal channel
// assumes los_pkg and the design compiled first; line traffic from line_source
module tb_line_loss_of_signal_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_ST = los_pkg::ADDR_ALARM_STATUS;
  localparam logic [7:0] A_DET = los_pkg::ADDR_DETECT_CTRL;
  localparam logic [7:0] A_OUT = los_pkg::ADDR_OUTPUT_CTRL;
  // ************************************************************
  // signals
  // ************************************************************
  logic ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic line_clk, line_pos, line_neg, amp_below_declare, amp_above_clear, pll_training;
  logic e3_mode, global_mute_on_loss, send_ones;
  logic [2:0] s;
  logic receive_signal_loss, receive_lock_loss, recovered_positive_rail, recovered_negative_rail;
  logic recovered_clock_out, equalizer_enable, line_codec_disable, receiver_shutdown;
  int n_errors = 0;
  int comparisons = 0;
  int cyc_cnt = 0;
  int t;
  line_loss_of_signal_monitor dut (.ref_clk, .reset, .clk_en(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .line_clk, .line_pos, .line_neg,
    .amp_below_declare, .amp_above_clear, .pll_training, .drive_monitor_flag(1'b0), .e3_mode,
    .global_mute_on_loss, .receive_signal_loss, .receive_lock_loss, .recovered_positive_rail,
    .recovered_negative_rail, .recovered_clock_out, .equalizer_enable, .line_codec_disable,
    .receiver_shutdown);
  line_source far_end (.send_ones, .line_clk, .line_pos, .line_neg);
  // ************************************************************
  // clock, timeout, helpers
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_errors++;
      $display("[ERR] %0t run timed out", $time);
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_rng(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[ERR] %0t %s: %0d cycles, allowed %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] sl, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sl;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    check(32'(n < 50), 32'h1, "bus answer");
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 4'hF, 32'h0);
    check(rd, exp, what);
  endtask
  task automatic wait_loss(input logic v, output int n);
    n = 0;
    while (receive_signal_loss !== v && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic poll(input int b, input logic v, output int n);
    int t0;
    t0 = cyc_cnt;
    do bus(1'b0, A_ST, 4'hF, 32'h0);
    while (rd[b] !== v && cyc_cnt - t0 < 3000);
    n = cyc_cnt - t0;
  endtask
  task automatic rails_seen(output logic [2:0] r);
    r = 3'h0;
    repeat (64) begin
      @(posedge ref_clk);
      r = r | {recovered_clock_out, recovered_negative_rail, recovered_positive_rail};
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_regs();
    rdchk(A_ST, 32'h0, "status reset");
    rdchk(A_DET, 32'h0, "detect reset");
    rdchk(A_OUT, 32'h0, "output reset");
    bus(1'b1, A_DET, 4'hF, 32'hFF);
    rdchk(A_DET, 32'h0F, "detect rw bits");
    check(32'({line_codec_disable, equalizer_enable}), 32'h3, "detect pins");
    bus(1'b1, A_OUT, 4'hE, 32'hFF);
    rdchk(A_OUT, 32'h0, "write without lane 0");
    bus(1'b1, A_OUT, 4'hF, 32'hFF);
    rdchk(A_OUT, 32'h1E, "output rw bits");
    check(32'(receiver_shutdown), 32'h1, "shutdown pin");
    bus(1'b1, 8'h0C, 4'hF, 32'hFF);
    rdchk(8'h0C, 32'h0, "unmapped read");
    bus(1'b1, A_DET, 4'hF, 32'h0);
    bus(1'b1, A_OUT, 4'hF, 32'h0);
    pll_training <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check(32'(receive_lock_loss), 32'h1, "lock loss pin");
    rdchk(A_ST, 32'h10, "lock loss bit");
    pll_training <= 1'b0;
    $display("registers test done");
  endtask
  task automatic test_e3();
    bus(1'b1, A_OUT, 4'hF, 32'h08);
    amp_below_declare <= 1'b1;
    amp_above_clear <= 1'b0;
    wait_loss(1'b1, t);
    check_rng(t, 80, 2040, "declare delay");
    rdchk(A_ST, 32'h0C, "analog loss status");
    rails_seen(s);
    check(32'(s), 32'h4, "muted rails");
    @(posedge ref_clk);
    amp_below_declare <= 1'b0;
    repeat (400) @(posedge ref_clk);
    check(32'(receive_signal_loss), 32'h1, "between thresholds");
    amp_above_clear <= 1'b1;
    wait_loss(1'b0, t);
    check_rng(t, 80, 2056, "clear delay");
    rdchk(A_ST, 32'h0, "status cleared");
    rails_seen(s);
    check(32'(s), 32'h7, "rails resume");
    bus(1'b1, A_OUT, 4'hF, 32'h10);
    repeat (2) @(posedge ref_clk);
    rails_seen(s);
    check(32'(s), 32'h5, "single rail");
    bus(1'b1, A_OUT, 4'hF, 32'h0);
    $display("amplitude test done");
  endtask
  task automatic test_ds3();
    e3_mode <= 1'b0;
    global_mute_on_loss <= 1'b1;
    send_ones <= 1'b0;
    poll(1, 1'b1, t);
    check_rng(t, 1024, 1576, "zero run length");
    wait_loss(1'b1, t);
    rdchk(A_ST, 32'h0A, "digital loss status");
    rails_seen(s);
    check(32'(s), 32'h4, "globally muted rails");
    send_ones <= 1'b1;
    poll(1, 1'b0, t);
    check_rng(t, 848, 1320, "dense windows");
    wait_loss(1'b0, t);
    check_rng(t, 80, 2056, "clear delay");
    amp_below_declare <= 1'b1;
    amp_above_clear <= 1'b0;
    wait_loss(1'b1, t);
    rdchk(A_ST, 32'h0C, "analog loss in ds3");
    rails_seen(s);
    check(32'(s), 32'h4, "mute with live data");
    amp_below_declare <= 1'b0;
    amp_above_clear <= 1'b1;
    wait_loss(1'b0, t);
    check_rng(t, 80, 2056, "ds3 clear delay");
    global_mute_on_loss <= 1'b0;
    $display("zero run test done");
  endtask
  task automatic test_dis();
    bus(1'b1, A_DET, 4'hF, 32'h06);
    amp_below_declare <= 1'b1;
    amp_above_clear <= 1'b0;
    send_ones <= 1'b0;
    s = 3'h0;
    repeat (2400) begin
      @(posedge ref_clk);
      s = s | {2'b00, receive_signal_loss};
    end
    check(32'(s), 32'h0, "no loss when disabled");
    rdchk(A_ST, 32'h0, "detectors silent");
    amp_below_declare <= 1'b0;
    amp_above_clear <= 1'b1;
    send_ones <= 1'b1;
    bus(1'b1, A_DET, 4'hF, 32'h0);
    $display("disable test done");
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    amp_below_declare = 1'b0;
    amp_above_clear = 1'b1;
    pll_training = 1'b0;
    e3_mode = 1'b1;
    global_mute_on_loss = 1'b0;
    send_ones = 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    test_regs();
    test_e3();
    test_ds3();
    test_dis();
    complete_run();
  end
endmodule // tb_line_loss_of_signal_monitor
